// ==== logic/dtc_cfg.svh ====
// Register offsets, field positions, reset values and code values for the terminal command logic.
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define DTC_OFS_CTRL        8'h00
`define DTC_OFS_IN_ASSIGN   8'h04
`define DTC_OFS_RUN_ASSIGN  8'h08
`define DTC_OFS_OUT1_SEL    8'h0C
`define DTC_OFS_OUT2_SEL    8'h10
`define DTC_OFS_RELAY_SEL   8'h14
`define DTC_OFS_DECEL_TIME  8'h18
`define DTC_OFS_STATUS      8'h1C

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DTC_CTRL_POL_BIT    0
`define DTC_CTRL_MODE_LSB   1
`define DTC_CTRL_CLR_BIT    3
`define DTC_ST_MON_LSB      8
`define DTC_ST_DECEL_BIT    16
`define DTC_ST_ALARM_BIT    17
`define DTC_ST_OUT_LSB      18

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define DTC_RST_OUT1_SEL    11'h000
`define DTC_RST_OUT2_SEL    11'h001
`define DTC_RST_RELAY_SEL   11'h063
`define DTC_RST_ASSIGN      8'h00
`define DTC_RST_RUN_A       8'h62
`define DTC_RST_RUN_B       8'h63
`define DTC_RST_DECEL_TIME  16'h0064

// ----------------------------------------------------------------------------
// Input command codes
// ----------------------------------------------------------------------------
`define DTC_IN_PID_CANCEL   8'h14
`define DTC_IN_INVERT       8'h15
`define DTC_IN_LINK_PRIO    8'h18
`define DTC_IN_MONITOR      8'h19
`define DTC_IN_SPEED_SRCH   8'h1A
`define DTC_IN_FORCED_STOP  8'h1E
`define DTC_IN_PID_CLEAR    8'h21
`define DTC_IN_PID_FREEZE   8'h22
`define DTC_IN_RUN_FWD      8'h62
`define DTC_IN_RUN_BWD      8'h63

// ----------------------------------------------------------------------------
// Output selection codes
// ----------------------------------------------------------------------------
`define DTC_NEG_OFFSET      11'h3E8
`define DTC_OC_RUN          11'h000
`define DTC_OC_FAR          11'h001
`define DTC_OC_FDT          11'h002
`define DTC_OC_LU           11'h003
`define DTC_OC_TORQ_POL     11'h004
`define DTC_OC_OUT_LIM      11'h005
`define DTC_OC_RESTART      11'h006
`define DTC_OC_OVL_WARN     11'h007
`define DTC_OC_READY        11'h00A
`define DTC_OC_FAR2         11'h015
`define DTC_OC_OUT_LIM2     11'h016
`define DTC_OC_AUTO_RST     11'h01A
`define DTC_OC_HEAT_WARN    11'h01C
`define DTC_OC_LIFE         11'h01E
`define DTC_OC_REF_LOSS     11'h021
`define DTC_OC_OUT_ON       11'h023
`define DTC_OC_OVL_PREV     11'h024
`define DTC_OC_CUR_DET      11'h025
`define DTC_OC_CUR_DET2     11'h026
`define DTC_OC_PID_ALARM    11'h02A
`define DTC_OC_MOTOR2       11'h031
`define DTC_OC_BRAKE        11'h039
`define DTC_OC_RSV_LO       11'h050
`define DTC_OC_RSV_HI       11'h052
`define DTC_OC_ALARM        11'h063

`endif

// ==== logic/dtc_pkg.sv ====
// Types shared by the terminal command logic.
`default_nettype none
package dtc_pkg;

  typedef logic [10:0] dtc_code_t;
  typedef logic [7:0]  dtc_asg_t;

  typedef enum logic [2:0] {
    DTC_FS_RUN   = 3'b001,
    DTC_FS_DECEL = 3'b010,
    DTC_FS_ALARM = 3'b100
  } dtc_fs_e;

  typedef struct packed {
    logic run;
    logic freq_reached_flag;
    logic freq_level_flag;
    logic undervoltage_flag;
    logic torque_polarity;
    logic output_limiting;
    logic restart_active;
    logic overload_warning;
    logic ready_to_run;
    logic freq_reached2;
    logic output_limiting2;
    logic auto_resetting;
    logic heatsink_warning;
    logic life_alarm;
    logic reference_loss;
    logic output_on;
    logic overload_prevent;
    logic current_detect;
    logic current_detect2;
    logic pid_alarm;
    logic motor2_selected;
    logic brake_command_out;
    logic any_fault_flag;
  } dtc_status_s;

  typedef struct packed {
    logic pid_enable;
    logic pid_out_inverse;
    logic manual_inverse;
    logic analog1_inverse;
    logic link_priority;
    logic idle_speed_search;
    logic pid_clear;
    logic pid_integral_freeze;
    logic run_forward;
    logic run_backward;
    logic forced_stop_decel;
    logic forced_stop_alarm;
  } dtc_drive_s;

endpackage
`default_nettype wire

// ==== logic/dtc_top.sv ====
// Terminal command decoder and programmable output router with an AHB-Lite register slave.
`timescale 1ns/1ps
`default_nettype none
`include "dtc_cfg.svh"

module dtc_top (
  input  wire logic                 CLK,
  input  wire logic                 NRST,
  input  wire logic                 HSEL,
  input  wire logic [31:0]          HADDR,
  input  wire logic [1:0]           HTRANS,
  input  wire logic                 HWRITE,
  input  wire logic [2:0]           HSIZE,
  input  wire logic [31:0]          HWDATA,
  input  wire logic                 HREADY,
  output logic      [31:0]          HRDATA,
  output logic                      HREADYOUT,
  output logic                      HRESP,
  input  wire logic [4:0]           TERM_IN,
  input  wire logic                 MOTOR_STOPPED,
  input  wire dtc_pkg::dtc_status_s STATUS_IN,
  output dtc_pkg::dtc_drive_s       DRIVE_OUT,
  output logic      [15:0]          FORCED_STOP_DECEL_TIME,
  output logic                      TRANSISTOR_OUT_A,
  output logic                      TRANSISTOR_OUT_B,
  output logic                      RELAY_CONTACTS
);
  import dtc_pkg::*;

  localparam int NTERM = 5;
  localparam int NGEN  = 3;

  // --------------------------------------------------------------------------
  // Decoding functions
  // --------------------------------------------------------------------------
  // Terminals 3 and 4 are the two dedicated run-assignment terminals.
  function automatic logic cmd_assigned(input dtc_asg_t [NTERM-1:0] asg, input dtc_asg_t code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NTERM; i++) begin
      if (asg[i] == code) begin
        if (i >= NGEN || (code != `DTC_IN_RUN_FWD && code != `DTC_IN_RUN_BWD)) begin
          hit = 1'b1;
        end
      end
    end
    return hit;
  endfunction

  function automatic logic cmd_on(input dtc_asg_t [NTERM-1:0] asg, input logic [NTERM-1:0] lvl,
                                  input dtc_asg_t code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NTERM; i++) begin
      if (asg[i] == code && lvl[i]) begin
        if (i >= NGEN || (code != `DTC_IN_RUN_FWD && code != `DTC_IN_RUN_BWD)) begin
          hit = 1'b1;
        end
      end
    end
    return hit;
  endfunction

  function automatic logic sel_out(input dtc_code_t code, input dtc_status_s st);
    dtc_code_t base;
    logic      neg;
    logic      sig;
    neg  = (code >= `DTC_NEG_OFFSET);
    base = neg ? code - `DTC_NEG_OFFSET : code;
    case (base)
      `DTC_OC_RUN:       sig = st.run;
      `DTC_OC_FAR:       sig = st.freq_reached_flag;
      `DTC_OC_FDT:       sig = st.freq_level_flag;
      `DTC_OC_LU:        sig = st.undervoltage_flag;
      `DTC_OC_TORQ_POL:  sig = st.torque_polarity;
      `DTC_OC_OUT_LIM:   sig = st.output_limiting;
      `DTC_OC_RESTART:   sig = st.restart_active;
      `DTC_OC_OVL_WARN:  sig = st.overload_warning;
      `DTC_OC_READY:     sig = st.ready_to_run;
      `DTC_OC_FAR2:      sig = st.freq_reached2;
      `DTC_OC_OUT_LIM2:  sig = st.output_limiting2;
      `DTC_OC_AUTO_RST:  sig = st.auto_resetting;
      `DTC_OC_HEAT_WARN: sig = st.heatsink_warning;
      `DTC_OC_LIFE:      sig = st.life_alarm;
      `DTC_OC_REF_LOSS:  sig = st.reference_loss;
      `DTC_OC_OUT_ON:    sig = st.output_on;
      `DTC_OC_OVL_PREV:  sig = st.overload_prevent;
      `DTC_OC_CUR_DET:   sig = st.current_detect;
      `DTC_OC_CUR_DET2:  sig = st.current_detect2;
      `DTC_OC_PID_ALARM: sig = st.pid_alarm;
      `DTC_OC_MOTOR2:    sig = st.motor2_selected;
      `DTC_OC_BRAKE:     sig = st.brake_command_out;
      `DTC_OC_ALARM:     sig = st.any_fault_flag;
      default:           sig = 1'b0;
    endcase
    // Codes past 1099 still count as active-OFF, land in the default above and so read 1.
    return sig ^ neg;
  endfunction

  // --------------------------------------------------------------------------
  // Terminal synchronisers
  // --------------------------------------------------------------------------
  logic [NTERM-1:0] sync1_q;
  logic [NTERM-1:0] sync2_q;
  logic [NTERM-1:0] sync3_q;
  logic [NTERM-1:0] level_q;
  logic [NTERM-1:0] level_d;

  genvar g;
  generate
    for (g = 0; g < NTERM; g++) begin : g_term
      // A level is only believed once two later stages agree, so a one-cycle glitch never counts.
      always_comb begin
        level_d[g] = (sync2_q[g] == sync3_q[g]) ? sync3_q[g] : level_q[g];
      end
    end
  endgenerate

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      level_q <= '0;
    end else begin
      sync1_q <= TERM_IN;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      level_q <= level_d;
    end
  end

  // --------------------------------------------------------------------------
  // AHB-Lite register slave
  // --------------------------------------------------------------------------
  logic                    pol_q;
  logic                    pol_d;
  logic [1:0]              mode_q;
  logic [1:0]              mode_d;
  dtc_asg_t [NTERM-1:0]    asg_q;
  dtc_asg_t [NTERM-1:0]    asg_d;
  dtc_code_t               sel1_q;
  dtc_code_t               sel1_d;
  dtc_code_t               sel2_q;
  dtc_code_t               sel2_d;
  dtc_code_t               selr_q;
  dtc_code_t               selr_d;
  logic [15:0]             decel_q;
  logic [15:0]             decel_d;
  logic                    wr_pend_q;
  logic                    wr_pend_d;
  logic [7:0]              wr_addr_q;
  logic [7:0]              wr_addr_d;
  logic [31:0]             rdata_q;
  logic [31:0]             rdata_d;
  logic                    alarm_clr;
  logic                    accept;
  logic [31:0]             status_word;
  dtc_fs_e                 fs_q;
  logic [NTERM-1:0]        monitor_bits;
  logic                    y1_q;
  logic                    y2_q;
  logic                    relay_q;

  assign accept    = HSEL && HTRANS[1] && HREADY;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign HRDATA    = rdata_q;

  always_comb begin
    for (int i = 0; i < NTERM; i++) begin
      monitor_bits[i] = level_q[i] && (asg_q[i] == `DTC_IN_MONITOR);
    end
    status_word = '0;
    status_word[NTERM-1:0] = level_q;
    status_word[`DTC_ST_MON_LSB +: NTERM] = monitor_bits;
    status_word[`DTC_ST_DECEL_BIT] = (fs_q == DTC_FS_DECEL);
    status_word[`DTC_ST_ALARM_BIT] = (fs_q == DTC_FS_ALARM);
    status_word[`DTC_ST_OUT_LSB +: 3] = {relay_q, y2_q, y1_q};
  end

  always_comb begin
    wr_pend_d = accept && HWRITE;
    wr_addr_d = accept ? HADDR[7:0] : wr_addr_q;
    rdata_d   = '0;
    if (accept && !HWRITE) begin
      case (HADDR[7:0])
        `DTC_OFS_CTRL:       rdata_d = {28'h000_0000, 1'b0, mode_q, pol_q};
        `DTC_OFS_IN_ASSIGN:  rdata_d = {8'h00, asg_q[2], asg_q[1], asg_q[0]};
        `DTC_OFS_RUN_ASSIGN: rdata_d = {16'h0000, asg_q[4], asg_q[3]};
        `DTC_OFS_OUT1_SEL:   rdata_d = {21'h00_0000, sel1_q};
        `DTC_OFS_OUT2_SEL:   rdata_d = {21'h00_0000, sel2_q};
        `DTC_OFS_RELAY_SEL:  rdata_d = {21'h00_0000, selr_q};
        `DTC_OFS_DECEL_TIME: rdata_d = {16'h0000, decel_q};
        `DTC_OFS_STATUS:     rdata_d = status_word;
        default:             rdata_d = '0;
      endcase
    end
    pol_d     = pol_q;
    mode_d    = mode_q;
    asg_d     = asg_q;
    sel1_d    = sel1_q;
    sel2_d    = sel2_q;
    selr_d    = selr_q;
    decel_d   = decel_q;
    alarm_clr = 1'b0;
    if (wr_pend_q) begin
      case (wr_addr_q)
        `DTC_OFS_CTRL: begin
          pol_d     = HWDATA[`DTC_CTRL_POL_BIT];
          mode_d    = HWDATA[`DTC_CTRL_MODE_LSB +: 2];
          alarm_clr = HWDATA[`DTC_CTRL_CLR_BIT];
        end
        `DTC_OFS_IN_ASSIGN: begin
          asg_d[0] = HWDATA[7:0];
          asg_d[1] = HWDATA[15:8];
          asg_d[2] = HWDATA[23:16];
        end
        `DTC_OFS_RUN_ASSIGN: begin
          asg_d[3] = HWDATA[7:0];
          asg_d[4] = HWDATA[15:8];
        end
        `DTC_OFS_OUT1_SEL:   sel1_d  = HWDATA[10:0];
        `DTC_OFS_OUT2_SEL:   sel2_d  = HWDATA[10:0];
        `DTC_OFS_RELAY_SEL:  selr_d  = HWDATA[10:0];
        `DTC_OFS_DECEL_TIME: decel_d = HWDATA[15:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q   <= '0;
      pol_q     <= 1'b0;
      mode_q    <= 2'h0;
      asg_q[0]  <= `DTC_RST_ASSIGN;
      asg_q[1]  <= `DTC_RST_ASSIGN;
      asg_q[2]  <= `DTC_RST_ASSIGN;
      asg_q[3]  <= `DTC_RST_RUN_A;
      asg_q[4]  <= `DTC_RST_RUN_B;
      sel1_q    <= `DTC_RST_OUT1_SEL;
      sel2_q    <= `DTC_RST_OUT2_SEL;
      selr_q    <= `DTC_RST_RELAY_SEL;
      decel_q   <= `DTC_RST_DECEL_TIME;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rdata_q   <= rdata_d;
      pol_q     <= pol_d;
      mode_q    <= mode_d;
      asg_q     <= asg_d;
      sel1_q    <= sel1_d;
      sel2_q    <= sel2_d;
      selr_q    <= selr_d;
      decel_q   <= decel_d;
    end
  end

  // --------------------------------------------------------------------------
  // Forced stop sequence
  // --------------------------------------------------------------------------
  logic    stop_on;
  logic    stop_prev_q;
  dtc_fs_e fs_d;

  // Without an assigned forced-stop terminal the drive is never held stopped.
  assign stop_on = !cmd_assigned(asg_q, `DTC_IN_FORCED_STOP) ||
                   cmd_on(asg_q, level_q, `DTC_IN_FORCED_STOP);

  always_comb begin
    fs_d = fs_q;
    case (fs_q)
      DTC_FS_RUN: begin
        if (stop_prev_q && !stop_on) begin
          fs_d = DTC_FS_DECEL;
        end
      end
      DTC_FS_DECEL: begin
        if (MOTOR_STOPPED) begin
          fs_d = DTC_FS_ALARM;
        end
      end
      DTC_FS_ALARM: begin
        // Leaving the alarm needs the stop terminal back ON, so a held stop cannot be cleared.
        if (alarm_clr && stop_on) begin
          fs_d = DTC_FS_RUN;
        end
      end
      default: fs_d = DTC_FS_RUN;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      fs_q        <= DTC_FS_RUN;
      stop_prev_q <= 1'b1;
    end else begin
      fs_q        <= fs_d;
      stop_prev_q <= stop_on;
    end
  end

  // --------------------------------------------------------------------------
  // Drive commands and output routing
  // --------------------------------------------------------------------------
  dtc_drive_s drv_q;
  dtc_drive_s drv_d;
  logic       invert_on;
  logic       cancel_on;
  logic       fwd_on;
  logic       bwd_on;
  logic       run_ok;
  logic       y1_d;
  logic       y2_d;
  logic       relay_d;

  assign invert_on = cmd_on(asg_q, level_q, `DTC_IN_INVERT);
  assign cancel_on = cmd_on(asg_q, level_q, `DTC_IN_PID_CANCEL);
  assign fwd_on    = cmd_on(asg_q, level_q, `DTC_IN_RUN_FWD);
  assign bwd_on    = cmd_on(asg_q, level_q, `DTC_IN_RUN_BWD);
  assign run_ok    = (fs_q == DTC_FS_RUN);

  always_comb begin
    drv_d = '0;
    drv_d.pid_enable          = (mode_q != 2'h0) && !cancel_on;
    drv_d.pid_out_inverse     = (mode_q == 2'h2) ^ invert_on;
    drv_d.manual_inverse      = pol_q;
    drv_d.analog1_inverse     = pol_q ^ invert_on;
    drv_d.link_priority       = !cmd_assigned(asg_q, `DTC_IN_LINK_PRIO) ||
                                cmd_on(asg_q, level_q, `DTC_IN_LINK_PRIO);
    drv_d.idle_speed_search   = cmd_on(asg_q, level_q, `DTC_IN_SPEED_SRCH);
    drv_d.pid_clear           = cmd_on(asg_q, level_q, `DTC_IN_PID_CLEAR);
    drv_d.pid_integral_freeze = cmd_on(asg_q, level_q, `DTC_IN_PID_FREEZE);
    // Both directions at once is ambiguous, so the drive is left to decelerate.
    drv_d.run_forward         = run_ok && fwd_on && !bwd_on;
    drv_d.run_backward        = run_ok && bwd_on && !fwd_on;
    drv_d.forced_stop_decel   = (fs_q == DTC_FS_DECEL);
    drv_d.forced_stop_alarm   = (fs_q == DTC_FS_ALARM);
    y1_d    = sel_out(sel1_q, STATUS_IN);
    y2_d    = sel_out(sel2_q, STATUS_IN);
    relay_d = sel_out(selr_q, STATUS_IN);
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      drv_q   <= '0;
      y1_q    <= 1'b0;
      y2_q    <= 1'b0;
      relay_q <= 1'b0;
    end else begin
      drv_q   <= drv_d;
      y1_q    <= y1_d;
      y2_q    <= y2_d;
      relay_q <= relay_d;
    end
  end

  assign DRIVE_OUT              = drv_q;
  assign FORCED_STOP_DECEL_TIME = decel_q;
  assign TRANSISTOR_OUT_A       = y1_q;
  assign TRANSISTOR_OUT_B       = y2_q;
  assign RELAY_CONTACTS         = relay_q;

endmodule
`default_nettype wire

// ==== tb/dtc_props.sv ====
// Port-level assertions for the terminal command logic.
`timescale 1ns/1ps
`default_nettype none
module dtc_props (
  input wire logic                CLK,
  input wire logic                NRST,
  input wire logic                HSEL,
  input wire logic [1:0]          HTRANS,
  input wire logic                HREADY,
  input wire logic [31:0]         HRDATA,
  input wire logic                HREADYOUT,
  input wire logic                HRESP,
  input wire logic [4:0]          TERM_IN,
  input wire logic                MOTOR_STOPPED,
  input wire dtc_pkg::dtc_drive_s DRIVE_OUT
);
  import dtc_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  property p_ok_resp;
    HREADYOUT && !HRESP;
  endproperty
  a_ok_resp: assert property (p_ok_resp) else $error("bus answer not ready or not okay");
  property p_rd_idle;
    !(HSEL && HTRANS[1] && HREADY) |=> HRDATA == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside a data phase");
  property p_prio_rst;
    $rose(NRST) |-> ##[1:3] DRIVE_OUT.link_priority;
  endproperty
  a_prio_rst: assert property (p_prio_rst) else $error("link priority off unassigned");
  property p_one_dir;
    !(DRIVE_OUT.run_forward && DRIVE_OUT.run_backward);
  endproperty
  a_one_dir: assert property (p_one_dir) else $error("both run directions on");
  property p_no_run_alarm;
    DRIVE_OUT.forced_stop_alarm |-> !DRIVE_OUT.run_forward && !DRIVE_OUT.run_backward;
  endproperty
  a_no_run_alarm: assert property (p_no_run_alarm) else $error("run during alarm");
  property p_alarm_src;
    $rose(DRIVE_OUT.forced_stop_alarm) |-> $past(DRIVE_OUT.forced_stop_decel);
  endproperty
  a_alarm_src: assert property (p_alarm_src) else $error("alarm without deceleration");
  property p_stop_alarm;
    DRIVE_OUT.forced_stop_decel && MOTOR_STOPPED |-> ##[1:3] DRIVE_OUT.forced_stop_alarm;
  endproperty
  a_stop_alarm: assert property (p_stop_alarm) else $error("no alarm after stop");
  property p_fwd_term;
    DRIVE_OUT.run_forward |-> $past(TERM_IN[3], 3) || $past(TERM_IN[3], 4)
                           || $past(TERM_IN[3], 5) || $past(TERM_IN[3], 6);
  endproperty
  a_fwd_term: assert property (p_fwd_term) else $error("forward without its terminal");
  c_alarm: cover property (DRIVE_OUT.forced_stop_alarm);
  c_fwd: cover property (DRIVE_OUT.run_forward);
  c_xfer: cover property (HSEL && HTRANS[1] && HREADY);
endmodule
bind dtc_top dtc_props u_props (.CLK(CLK), .NRST(NRST), .HSEL(HSEL), .HTRANS(HTRANS),
  .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .TERM_IN(TERM_IN), .MOTOR_STOPPED(MOTOR_STOPPED), .DRIVE_OUT(DRIVE_OUT));
`default_nettype wire

// ==== tb/dtc_ext_equip.sv ====
// Model of the external equipment wired to the terminals, with a simple motor.
`timescale 1ns/1ps
`default_nettype none
module dtc_ext_equip #(
  parameter int STOP_CYC = 6,
  parameter int MASK_CYC = 40
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [4:0] want,
  input  wire logic       decel,
  input  wire logic       run,
  output logic      [4:0] term,
  output logic            stopped,
  output logic            outs_valid
);
  int unsigned spin_q = 0;
  int unsigned age_q = 0;
  // Mask time is far shorter than on real equipment so the run stays short.
  assign outs_valid = age_q >= MASK_CYC;
  always @(posedge clk) begin
    term <= want;
    if (!nrst) begin
      spin_q <= 0;
      age_q <= 0;
      stopped <= 1'b0;
    end else begin
      spin_q <= decel ? spin_q + 1 : 0;
      stopped <= !run && (stopped || (decel && spin_q >= STOP_CYC));
      if (age_q < MASK_CYC) age_q <= age_q + 1;
    end
  end
endmodule
`default_nettype wire

// ==== tb/dtc_top_tb.sv ====
// Self-checking testbench for the terminal command logic.
`timescale 1ns/1ps
`default_nettype none
module dtc_top_tb;
  import dtc_pkg::*;
  logic        clk = 0, nrst = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rnd = 32'h0001_7E49;
  logic [1:0]  htrans = 0;
  logic [4:0]  want = 0, term;
  logic        stopped, outs_valid, ya, yb, rly;
  logic [15:0] dec_t;
  dtc_status_s st = '0;
  dtc_drive_s  drv;
  int          fail_count = 0, checks = 0, cyc = 0;
  logic [7:0]  cmd [5] = '{8'h18, 8'h19, 8'h1A, 8'h21, 8'h22};
  logic [7:0]  codes [27] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h0A,
    8'h15, 8'h16, 8'h1A, 8'h1C, 8'h1E, 8'h21, 8'h23, 8'h24, 8'h25, 8'h26, 8'h2A, 8'h31, 8'h39,
    8'h63, 8'h50, 8'h51, 8'h52, 8'h53};
  logic [31:0] rst_v [9] = '{32'h0, 32'h0, 32'h0000_6362, 32'h0, 32'h1, 32'h0000_0063,
    32'h0000_0064, 32'h0, 32'h0};
  always #10 clk = ~clk;
  dtc_top dut (.CLK(clk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .TERM_IN(term), .MOTOR_STOPPED(stopped),
    .STATUS_IN(st), .DRIVE_OUT(drv), .FORCED_STOP_DECEL_TIME(dec_t),
    .TRANSISTOR_OUT_A(ya), .TRANSISTOR_OUT_B(yb), .RELAY_CONTACTS(rly));
  dtc_ext_equip u_ext (.clk(clk), .nrst(nrst), .want(want), .decel(drv.forced_stop_decel),
    .run(drv.run_forward | drv.run_backward), .term(term), .stopped(stopped),
    .outs_valid(outs_valid));
  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Probe codes past the listed ones never match, so the output shows its idle level.
  function automatic logic exp_out(input logic [10:0] c, input dtc_status_s s);
    logic [10:0] b;
    logic [22:0] v;
    logic        h;
    b = (c >= 11'h3E8) ? c - 11'h3E8 : c;
    v = s;
    h = 1'b0;
    for (int i = 0; i < 23; i++) if (b == {3'h0, codes[i]}) h = v[22 - i];
    return h ^ (c >= 11'h3E8);
  endfunction
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic settle;
    repeat (8) @(posedge clk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      tally_and_finish;
    end
  end
  initial begin
    logic [31:0] x;
    logic [10:0] c;
    logic        b;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    foreach (rst_v[i]) begin
      ahb(1'b0, 8'(i * 4), 32'h0, x);
      chk("reset", x, rst_v[i]);
    end
    $display("reset values done");
    ahb(1'b1, 8'h04, 32'h0000_1415, x);
    for (int k = 0; k < 16; k++) begin
      rnd = lfsr(rnd);
      ahb(1'b1, 8'h00, {29'h0, k[2:0]}, x);
      want <= {3'h0, rnd[0], k[3]};
      settle;
      chk("a1inv", drv.analog1_inverse, k[0] ^ k[3]);
      chk("maninv", drv.manual_inverse, k[0]);
      chk("pidinv", drv.pid_out_inverse, (k[2:1] == 2) ^ k[3]);
      chk("piden", drv.pid_enable, (k[2:1] != 0) && !rnd[0]);
    end
    $display("polarity done");
    chk("mask", outs_valid, 1'b1);
    for (int n = 0; n < 54; n++) begin
      rnd = lfsr(rnd);
      c = {3'h0, codes[n % 27]} + ((n > 26) ? 11'h3E8 : 11'h000);
      ahb(1'b1, 8'h0C, {21'h0, c}, x);
      ahb(1'b1, 8'h10, {21'h0, c}, x);
      st <= dtc_status_s'(rnd[22:0]);
      repeat (3) @(posedge clk);
      chk("out_a", ya, exp_out(c, st));
      chk("out_b", yb, exp_out(c, st));
    end
    for (int n = 0; n < 4; n++) begin
      ahb(1'b1, 8'h14, n[1] ? 32'h0000_044B : 32'h0000_0063, x);
      st.any_fault_flag <= n[0];
      repeat (3) @(posedge clk);
      chk("relay", rly, n[0] ^ n[1]);
    end
    $display("outputs done");
    foreach (cmd[i]) begin
      ahb(1'b1, 8'h04, {24'h0, cmd[i]}, x);
      for (int on = 0; on < 2; on++) begin
        b = on[0];
        want <= {4'h0, b};
        settle;
        ahb(1'b0, 8'h1C, 32'h0, x);
        chk("mon", x[8], i == 1 && b);
        chk("cmd", {drv.link_priority, drv.idle_speed_search, drv.pid_clear,
          drv.pid_integral_freeze}, {i != 0 || b, i == 2 && b, i == 3 && b, i == 4 && b});
      end
    end
    $display("commands done");
    rnd = lfsr(rnd);
    ahb(1'b1, 8'h18, {16'h0, rnd[15:0]}, x);
    @(posedge clk);
    chk("dtime", dec_t, rnd[15:0]);
    ahb(1'b1, 8'h04, 32'h0000_621E, x);
    want <= 5'h03;
    settle;
    chk("gen_fwd", drv.run_forward, 1'b0);
    want <= 5'h09;
    settle;
    chk("fwd", drv.run_forward, 1'b1);
    want <= 5'h11;
    settle;
    chk("bwd", {drv.run_forward, drv.run_backward}, 2'b01);
    want <= 5'h10;
    for (int t = 0; t < 30 && drv.forced_stop_decel !== 1'b1; t++) @(posedge clk);
    chk("decel", {drv.forced_stop_decel, drv.run_backward}, 2'b10);
    for (int t = 0; t < 40 && drv.forced_stop_alarm !== 1'b1; t++) @(posedge clk);
    chk("alarm", drv.forced_stop_alarm, 1'b1);
    want <= 5'h01;
    settle;
    ahb(1'b1, 8'h00, 32'h0000_0008, x);
    repeat (3) @(posedge clk);
    chk("clear", drv.forced_stop_alarm, 1'b0);
    want <= 5'h09;
    settle;
    chk("fwd2", drv.run_forward, 1'b1);
    want <= 5'h01;
    settle;
    chk("fwd_off", drv.run_forward, 1'b0);
    $display("run and stop done");
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    ahb(1'b0, 8'h14, 32'h0, x);
    chk("rst_relay", x, 32'h0000_0063);
    chk("rst_prio", drv.link_priority, 1'b1);
    $display("mid-run reset done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
